/* hw/lsi_pkg.sv */
// Package of constants and types for the status indicator block
package lsi_pkg;

  // System clock rate and default blink half period
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned BLINK_HALF_MS   = 250;
  localparam int unsigned BLINK_HALF_CYC  = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam int unsigned BLINK_CNT_W     = 32;

  // Index of the last phase in the rotating three phase error pattern
  localparam logic [1:0]  ERR_PHASE_LAST  = 2'h2;

  // Wired link speed codes
  typedef enum logic [1:0]
  {
    LSI_WIRED_DOWN = 2'b00,
    LSI_WIRED_10   = 2'b01,
    LSI_WIRED_100  = 2'b10
  } lsi_wired_t;

  // Wireless association codes
  typedef enum logic [1:0]
  {
    LSI_WL_NONE  = 2'b00,
    LSI_WL_ASSOC = 2'b01,
    LSI_WL_ADDR  = 2'b10
  } lsi_wireless_t;

  // Security operating modes
  typedef enum logic [1:0]
  {
    LSI_MODE_NON  = 2'b00,
    LSI_MODE_LINK = 2'b01,
    LSI_MODE_APP  = 2'b10
  } lsi_mode_t;

  // Display state
  typedef enum logic [0:0]
  {
    LSI_ST_NORMAL = 1'b0,
    LSI_ST_ERROR  = 1'b1
  } lsi_state_t;

  // Firmware status bundle
  typedef struct packed
  {
    lsi_wired_t    wired;
    lsi_wireless_t wireless;
    logic          fw_update;
    logic          error;
  } lsi_status_t;

  // Off and on levels of the lamp outputs
  localparam logic LED_OFF = 1'b0;
  localparam logic LED_ON  = 1'b1;

endpackage : lsi_pkg

/* hw/lsi_blink_gen.sv */
// Common blink timebase: square wave plus a three phase error sequence
module lsi_blink_gen
  import lsi_pkg::*;
(
  input  wire logic                   clock_in,
  input  wire logic                   rst_in,
  input  wire logic [BLINK_CNT_W-1:0] half_period_in,
  output logic                        blink_out,
  output logic [1:0]                  phase_out
);

  logic [BLINK_CNT_W-1:0] count;
  logic                   wrap;
  logic [BLINK_CNT_W-1:0] last;

  // A zero period is treated as one cycle so the counter never stalls
  assign last = (half_period_in == '0) ? '0 : half_period_in - 1'b1;
  assign wrap = (count >= last);

  // One counter serves every blinking line so they stay in step
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count     <= '0;
      blink_out <= 1'b0;
      phase_out <= 2'h0;
    end
    else if (wrap)
    begin
      count     <= '0;
      blink_out <= ~blink_out;
      phase_out <= (phase_out == ERR_PHASE_LAST) ? 2'h0 : phase_out + 2'h1;
    end
    else
    begin
      count <= count + 1'b1;
    end
  end

endmodule : lsi_blink_gen

/* hw/lsi_led_status.sv */
// Status indicator driver: wired pair, power, wireless and mode lamps
module lsi_led_status
  import lsi_pkg::*;
#(
  parameter logic [BLINK_CNT_W-1:0] BLINK_HALF = BLINK_CNT_W'(BLINK_HALF_CYC)
)
(
  input  wire logic                   clock_in,
  input  wire logic                   rst_in,
  input  wire lsi_pkg::lsi_status_t   status_in,
  input  wire lsi_pkg::lsi_mode_t     mode_cfg_in,
  input  wire logic [BLINK_CNT_W-1:0] blink_half_in,
  input  wire logic                   blink_use_param_in,
  output logic                        wired_amber_led_out,
  output logic                        wired_green_led_out,
  output logic                        power_led_out,
  output logic                        wireless_led_out,
  output logic                        mode_led_out,
  output logic                        data_enable_out,
  output logic                        error_out
);

  import lsi_pkg::*;

  lsi_state_t state;
  lsi_state_t next_state;
  lsi_mode_t  active_mode;
  logic       mode_loaded;
  logic       blink;
  logic [1:0] phase;
  logic [BLINK_CNT_W-1:0] half_sel;
  logic       next_amber;
  logic       next_green;
  logic       next_power;
  logic       next_wireless;
  logic       next_mode;
  logic       in_error;

  // Period choice: software value, or the build default when asked
  assign half_sel = blink_use_param_in ? BLINK_HALF : blink_half_in;

  lsi_blink_gen u_blink
  (
    .clock_in       (clock_in),
    .rst_in         (rst_in),
    .half_period_in (half_sel),
    .blink_out      (blink),
    .phase_out      (phase)
  );

  // Error is sticky; only the asynchronous reset leaves it
  assign next_state = (state == LSI_ST_ERROR || status_in.error) ? LSI_ST_ERROR : LSI_ST_NORMAL;
  assign in_error   = (next_state == LSI_ST_ERROR);

  // Wired pair follows link speed; an unknown code shows as down
  assign next_amber = (status_in.wired == LSI_WIRED_100);
  assign next_green = (status_in.wired == LSI_WIRED_10) ||
                      (status_in.wired == LSI_WIRED_100);

  // Three status lines, overridden by the rotating error pattern
  always_comb
  begin
    next_power    = LED_ON;
    next_wireless = LED_OFF;
    next_mode     = LED_OFF;
    if (in_error)
    begin
      next_power    = (phase == 2'h0);
      next_wireless = (phase == 2'h1);
      next_mode     = (phase == ERR_PHASE_LAST);
    end
    else
    begin
      next_power = status_in.fw_update ? blink : LED_ON;
      case (status_in.wireless)
        LSI_WL_ASSOC: next_wireless = blink;
        LSI_WL_ADDR:  next_wireless = LED_ON;
        default:      next_wireless = LED_OFF;
      endcase
      case (active_mode)
        LSI_MODE_LINK: next_mode = LED_ON;
        LSI_MODE_APP:  next_mode = blink;
        default:       next_mode = LED_OFF;
      endcase
    end
  end

  // Mode is captured once after reset release, so later changes wait for reset
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      active_mode <= LSI_MODE_NON;
      mode_loaded <= 1'b0;
    end
    else if (!mode_loaded)
    begin
      active_mode <= mode_cfg_in;
      mode_loaded <= 1'b1;
    end
  end

  // State and registered outputs: five lamps and two dedicated lines
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state               <= LSI_ST_NORMAL;
      wired_amber_led_out <= LED_OFF;
      wired_green_led_out <= LED_OFF;
      power_led_out       <= LED_OFF;
      wireless_led_out    <= LED_OFF;
      mode_led_out        <= LED_OFF;
      data_enable_out     <= 1'b0;
      error_out           <= 1'b0;
    end
    else
    begin
      state               <= next_state;
      wired_amber_led_out <= next_amber;
      wired_green_led_out <= next_green;
      power_led_out       <= next_power;
      wireless_led_out    <= next_wireless;
      mode_led_out        <= next_mode & mode_loaded;
      data_enable_out     <= ~in_error;
      error_out           <= in_error;
    end
  end

endmodule : lsi_led_status

/* bench/lsi_lamp_model.sv */
// Lamp panel model: tallies lit cycles of each lamp while a window is open
module lsi_lamp_model
(
  input  wire logic        clock_in,
  input  wire logic        window_in,
  input  wire logic [4:0]  lamps_in,
  output logic      [39:0] lit_count_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Closed window clears the tally, so each window starts from zero
  always @(posedge clock_in)
    for (int i = 0; i < 5; i++)
      lit_count_out[8*i +: 8] <= window_in ? lit_count_out[8*i +: 8] + 8'(lamps_in[i]) : 8'h00;
endmodule : lsi_lamp_model

/* bench/lsi_led_status_properties.sv */
// Port checks for the status indicator driver
module lsi_led_status_properties
  import lsi_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire lsi_status_t status_in,
  input wire logic        wired_amber_led_out,
  input wire logic        wired_green_led_out,
  input wire logic        power_led_out,
  input wire logic        wireless_led_out,
  input wire logic        mode_led_out,
  input wire logic        data_enable_out,
  input wire logic        error_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Normal display applies only with no error raised or latched
  wire calm = !status_in.error && !error_out;
  // Error display: paths shut, one of three lamps lit at a time
  sequence s_err_shown;
    error_out && !data_enable_out && $onehot({power_led_out, wireless_led_out, mode_led_out});
  endsequence
  a_wired_down: assert property (status_in.wired == LSI_WIRED_DOWN |=> !wired_amber_led_out && !wired_green_led_out)
    else $error("wired lamp lit with no link");
  a_wired_ten: assert property (status_in.wired == LSI_WIRED_10 |=> !wired_amber_led_out && wired_green_led_out)
    else $error("wrong wired lamps at low speed");
  a_wired_hundred: assert property (status_in.wired == LSI_WIRED_100 |=> wired_amber_led_out && wired_green_led_out)
    else $error("wrong wired lamps at high speed");
  a_power_steady: assert property (calm && !status_in.fw_update |=> power_led_out)
    else $error("power lamp not steady");
  a_wireless_none: assert property (calm && status_in.wireless == LSI_WL_NONE |=> !wireless_led_out)
    else $error("wireless lamp lit with no link");
  a_wireless_addr: assert property (calm && status_in.wireless == LSI_WL_ADDR |=> wireless_led_out)
    else $error("wireless lamp not steady");
  a_error_entry: assert property (status_in.error |=> s_err_shown [*3])
    else $error("error display wrong");
  a_error_hold: assert property (error_out |=> error_out && !data_enable_out)
    else $error("error display dropped");
  a_data_enable: assert property (calm |=> data_enable_out)
    else $error("data paths shut without error");
endmodule : lsi_led_status_properties

bind lsi_led_status lsi_led_status_properties i_props (.clock_in(clock_in), .rst_in(rst_in), .status_in(status_in),
  .wired_amber_led_out(wired_amber_led_out), .wired_green_led_out(wired_green_led_out), .power_led_out(power_led_out),
  .wireless_led_out(wireless_led_out), .mode_led_out(mode_led_out), .data_enable_out(data_enable_out),
  .error_out(error_out));

/* bench/tb_top.sv */
// Self-checking bench for the status indicator driver
module tb_top
  import lsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in = 1'b0;
  logic        rst_in   = 1'b1;
  logic        window   = 1'b0;
  lsi_status_t status   = '0;
  lsi_mode_t   mode_cfg = LSI_MODE_NON;
  logic        use_param = 1'b0;
  wire  [4:0]  lamps;
  wire         data_en;
  wire         err_out;
  wire  [39:0] lit;
  int          miscompares = 0;
  int          checks = 0;
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
  // Build default of 24 cycles differs from the software value of 4, so the selector is seen in the tally
  lsi_led_status #(.BLINK_HALF(32'h18)) i_dut (.clock_in(clock_in), .rst_in(rst_in), .status_in(status),
    .mode_cfg_in(mode_cfg), .blink_half_in(32'h4), .blink_use_param_in(use_param), .wired_amber_led_out(lamps[4]),
    .wired_green_led_out(lamps[3]), .power_led_out(lamps[2]), .wireless_led_out(lamps[1]),
    .mode_led_out(lamps[0]), .data_enable_out(data_en), .error_out(err_out));
  lsi_lamp_model i_lamps (.clock_in(clock_in), .window_in(window), .lamps_in(lamps), .lit_count_out(lit));
  // Clock at 200 MHz
  initial
  begin
    forever #2.5 clock_in = ~clock_in;
  end
  // Reset with a mode, then move the mode input to check that a late change is ignored
  task automatic restart(input lsi_mode_t m);
    rst_in = 1'b1;
    mode_cfg = m;
    repeat (3) @(posedge clock_in);
    #1 rst_in = 1'b0;
    @(posedge clock_in);
    #1 mode_cfg = (m == LSI_MODE_APP) ? LSI_MODE_LINK : LSI_MODE_APP;
  endtask : restart
  // Window of 24 cycles: blink gives 12 lit, error rotation 8, steady 24
  task automatic show(input lsi_status_t s, input logic [39:0] exp);
    status = s;
    repeat (4) @(posedge clock_in);
    #1 window = 1'b1;
    repeat (24) @(posedge clock_in);
    #1 window = 1'b0;
    `CHK(lit, exp)
  endtask : show
  task automatic end_of_test;
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  // Lamp bytes from high to low: amber, green, power, wireless, mode
  initial
  begin
    restart(LSI_MODE_LINK);
    show('{LSI_WIRED_DOWN, LSI_WL_NONE, 1'b0, 1'b0}, 40'h0000180018);
    show('{LSI_WIRED_10, LSI_WL_ASSOC, 1'b1, 1'b0}, 40'h00180C0C18);
    show('{LSI_WIRED_100, LSI_WL_ADDR, 1'b0, 1'b0}, 40'h1818181818);
    `CHK(data_en, 1'b1)
    restart(LSI_MODE_APP);
    show('{LSI_WIRED_DOWN, LSI_WL_ADDR, 1'b0, 1'b0}, 40'h000018180C);
    restart(LSI_MODE_NON);
    show('{LSI_WIRED_10, LSI_WL_NONE, 1'b0, 1'b0}, 40'h0018180000);
    show('{LSI_WIRED_100, LSI_WL_ASSOC, 1'b0, 1'b1}, 40'h1818080808);
    show('{LSI_WIRED_100, LSI_WL_ADDR, 1'b1, 1'b0}, 40'h1818080808);
    `CHK({err_out, data_en}, 2'b10)
    restart(LSI_MODE_LINK);
    show('{LSI_WIRED_100, LSI_WL_ADDR, 1'b0, 1'b0}, 40'h1818181818);
    `CHK({err_out, data_en}, 2'b01)
    // Half period 24 from reset: power blink first lights in the last 4 window cycles
    use_param = 1'b1;
    restart(LSI_MODE_LINK);
    show('{LSI_WIRED_DOWN, LSI_WL_NONE, 1'b1, 1'b0}, 40'h0000040018);
    end_of_test();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #20000;
    miscompares++;
    end_of_test();
  end
endmodule : tb_top
